// ===== bus_cycle_ctrl.sv
// Bus cycle controller: starts cycles, holds through wait states, ends bursts
// Operation
// - Zero wait non-burst cycle takes two clocks
// - Sample ready from second clock until seen
// - Last-transfer high in clock two when burstable
// - No ready seen keeps the cycle open
// - Burst moves one word each burst ready
`timescale 1ns/1ps

module bus_cycle_ctrl
  import bus_cycle_pkg::*;
#(
  parameter int BURST_LEN = bus_cycle_pkg::BURST_WORDS,
  parameter int BUF_WORDS = bus_cycle_pkg::BUF_DEPTH
) (
  input  wire logic                             clk,
  input  wire logic                             nrst,
  input  wire logic                             req_valid,
  input  wire bus_cycle_pkg::req_type           req,
  output logic                                  req_ready,
  output logic                                  addr_strobe_n,
  output logic [bus_cycle_pkg::ADDR_W-1:0]      bus_addr,
  output logic                                  bus_write,
  output logic [bus_cycle_pkg::DATA_W-1:0]      bus_wdata,
  output logic                                  last_transfer_n,
  input  wire logic                             ready_n,
  input  wire logic                             burst_ready_n,
  input  wire logic [bus_cycle_pkg::DATA_W-1:0] bus_rdata,
  output logic                                  wr_done,
  output logic                                  rd_valid,
  output bus_cycle_pkg::word_type               rd_word,
  input  wire logic                             rd_ready
);
  import bus_cycle_pkg::*;

  localparam int BW = $clog2(BURST_LEN);        // Beat counter width
  localparam int CW = $clog2(BUF_WORDS + 1);    // Buffer count width
  localparam int WW = $bits(word_type);         // Buffered word width

  // Refuse a burst or buffer the logic cannot serve
  if (BURST_LEN < 2 || BUF_WORDS < 2) begin : g_param_check
    $error("bus_cycle_ctrl needs BURST_LEN and BUF_WORDS of at least 2");
  end

  // Whole controller state
  typedef struct packed {
    state_type         st;       // Cycle phase
    logic              ads_n;    // Cycle start strobe, low in first clock
    logic [ADDR_W-1:0] addr;     // Current word address
    logic              write;    // Cycle direction
    logic [DATA_W-1:0] wdata;    // Write data held on the bus
    logic              last_n;   // Last-transfer indication
    logic              ready;    // Core may hand over a request
    logic              wr_done;  // Write finished pulse
    logic [BW-1:0]     beat;     // Words already moved in this cycle
  } ctrl_state_type;

  localparam ctrl_state_type RESET_STATE = '{
    st: ST_IDLE, ads_n: 1'b1, addr: '0, write: 1'b0, wdata: '0,
    last_n: 1'b1, ready: 1'b1, wr_done: 1'b0, beat: '0};

  ctrl_state_type  s_r;          // Registered state
  ctrl_state_type  s_nxt;        // Next state
  logic            hit;          // Some ready seen at this edge
  logic            ends;         // This edge closes the cycle
  logic            take;         // Request accepted
  logic            push;         // Read word enters the buffer
  word_type        push_word;    // Word offered to the buffer
  logic            buf_in_ready; // Buffer has a free slot
  logic [CW-1:0]   buf_cnt_nxt;  // Buffer fill after this edge
  logic [WW-1:0]   buf_out;      // Raw buffered word
  logic            room_for_two; // Burst may run past the next word

  // Ready sampling and cycle end decision
  always_comb begin
    hit  = !ready_n || !burst_ready_n;
    // Plain ready always ends; burst ready ends once last is flagged
    ends = !ready_n || !s_r.last_n;
    take = (s_r.st == ST_IDLE) && req_valid && s_r.ready;
    // Two free slots after this edge keep one more burst word safe
    room_for_two = (int'(buf_cnt_nxt) + 2 <= BUF_WORDS);
  end

  // Next state
  always_comb begin
    s_nxt         = s_r;
    s_nxt.ads_n   = 1'b1;
    s_nxt.wr_done = 1'b0;
    push          = 1'b0;
    push_word     = '{last: 1'b0, data: bus_rdata};
    unique case (s_r.st)
      // Waiting for a request
      ST_IDLE: begin
        if (take) begin
          s_nxt.st     = ST_ADDR;
          s_nxt.ads_n  = 1'b0;
          s_nxt.addr   = req.addr;
          s_nxt.write  = req.write;
          s_nxt.wdata  = req.wdata;
          s_nxt.beat   = '0;
          // Burst offered only for reads the core can take
          s_nxt.last_n = req.burst && !req.write;
        end
      end
      // First clock: address out, ready not looked at
      ST_ADDR: begin
        s_nxt.st = ST_DATA;
      end
      // Second clock onward: ready sampled every edge
      ST_DATA: begin
        if (hit) begin
          if (!s_r.write) begin
            push      = buf_in_ready;
            push_word = '{last: ends, data: bus_rdata};
          end
          if (ends) begin
            s_nxt.st      = ST_IDLE;
            s_nxt.last_n  = 1'b1;
            s_nxt.wr_done = s_r.write;
          end else begin
            // Next burst word; cut the burst short when the buffer is tight
            s_nxt.beat   = s_r.beat + BW'(1);
            s_nxt.addr   = s_r.addr + ADDR_W'(WORD_BYTES);
            s_nxt.last_n = !((s_r.beat + BW'(1) == BW'(BURST_LEN - 1)) || !room_for_two);
          end
        end
        // No ready: stay in data phase, one wait state per edge
      end
    endcase
    // A new request only with an empty buffer, so a burst always has room
    s_nxt.ready = (s_nxt.st == ST_IDLE) && !take && (buf_cnt_nxt == '0);
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Read words wait here so a stalled core loses nothing
  word_buffer #(
    .WIDTH (WW),
    .DEPTH (BUF_WORDS)
  ) u_rd_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_data   (push_word),
    .in_ready  (buf_in_ready),
    .out_valid (rd_valid),
    .out_data  (buf_out),
    .out_ready (rd_ready),
    .count_nxt (buf_cnt_nxt)
  );

  // Outputs straight from the state register and the read buffer head
  assign req_ready       = s_r.ready;
  assign addr_strobe_n   = s_r.ads_n;
  assign bus_addr        = s_r.addr;
  assign bus_write       = s_r.write;
  assign bus_wdata       = s_r.wdata;
  assign last_transfer_n = s_r.last_n;
  assign wr_done         = s_r.wr_done;
  assign rd_word         = word_type'(buf_out);

endmodule // bus_cycle_ctrl

// ===== bus_cycle_monitor.sv
// Checker of the bus cycle handshakes at the controller ports
`timescale 1ns/1ps
module bus_cycle_monitor
  import bus_cycle_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic                   req_valid,
  input wire bus_cycle_pkg::req_type req,
  input wire logic                   req_ready,
  input wire logic                   addr_strobe_n,
  input wire logic [31:0]            bus_addr,
  input wire logic                   bus_write,
  input wire logic                   last_transfer_n,
  input wire logic                   ready_n,
  input wire logic                   burst_ready_n,
  input wire logic                   wr_done,
  input wire logic                   rd_valid
);
  logic data_r; // Past the first clock of a cycle
  logic fin;    // An ending ready at this edge
  assign fin = data_r & (~ready_n | (~burst_ready_n & ~last_transfer_n));
  // Data phase tracker, opened by the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) data_r <= 1'b0;
    else data_r <= ~addr_strobe_n | (data_r & ~fin);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr; !addr_strobe_n && bus_write; endsequence
  sequence s_fill; req_valid && req_ready && req.burst && !req.write; endsequence
  a_strobe_one: assert property ($fell(addr_strobe_n) |=> addr_strobe_n)
    else $error("strobe longer than one clock");
  a_strobe_cause: assert property ($fell(addr_strobe_n) |-> $past(req_valid && req_ready))
    else $error("strobe without a taken request");
  a_write_two: assert property (s_wr ##1 !ready_n |=> wr_done)
    else $error("zero wait write not done");
  a_done_cause: assert property (wr_done |-> $past(fin && bus_write))
    else $error("write done without sampled ready");
  a_wait_open: assert property (data_r && ready_n && burst_ready_n
    |=> data_r && addr_strobe_n && !req_ready && !wr_done) else $error("cycle closed in wait");
  a_fill_last: assert property (s_fill |=> last_transfer_n [*2])
    else $error("last transfer low on burstable read");
  a_write_last: assert property (s_wr |-> !last_transfer_n)
    else $error("write not marked last");
  a_burst_step: assert property (data_r && !burst_ready_n && ready_n && last_transfer_n
    |=> data_r && bus_addr == $past(bus_addr) + 32'h4) else $error("burst address step wrong");
  a_word_out: assert property (data_r && !bus_write && !(ready_n && burst_ready_n)
    |=> rd_valid) else $error("read word not buffered");
endmodule // bus_cycle_monitor

bind bus_cycle_ctrl bus_cycle_monitor mon_u (.clk, .nrst, .req_valid, .req, .req_ready,
  .addr_strobe_n, .bus_addr, .bus_write, .last_transfer_n, .ready_n, .burst_ready_n,
  .wr_done, .rd_valid);

// ===== bus_cycle_pkg.sv
// Shared constants and carriers for the processor bus cycle controller
package bus_cycle_pkg;

  localparam int ADDR_W       = 32;   // Bus address width
  localparam int DATA_W       = 32;   // Bus data width
  localparam int WORD_BYTES   = 4;    // Bytes moved per transfer
  localparam int BURST_WORDS  = 4;    // Words per line fill
  localparam int BUF_DEPTH    = 2;    // Read buffer entries
  localparam int T_MIN_CYCLES = 2;    // Least clocks of a zero wait cycle

  // Cycle states, Gray along idle -> address -> data
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11
  } state_type;

  // One bus request from the core side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;    // Start address
    logic [DATA_W-1:0] wdata;   // Write data
    logic              write;   // 1 = write cycle
    logic              burst;   // Core can take a burst
  } req_type;

  // One word returned to the core side
  typedef struct packed {
    logic              last;    // Final word of the cycle
    logic [DATA_W-1:0] data;    // Read data
  } word_type;

endpackage

// ===== memory_model.sv
// Memory side model: answers bus cycles after programmed waits
`timescale 1ns/1ps
module memory_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        addr_strobe_n,
  input  wire logic [31:0] bus_addr,
  input  wire logic        last_transfer_n,
  input  wire logic [7:0]  waits,
  input  wire logic        use_burst,
  output logic             ready_n,
  output logic             burst_ready_n,
  output logic [31:0]      bus_rdata
);
  logic        act; // Cycle open
  logic        fin; // Cycle ends at this edge
  logic        hit; // Answer in the next clock
  logic [7:0]  cnt; // Waits left
  logic [31:0] a;   // Current word address
  // Each edge decides what the next clock shows
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act = 1'b0;
      ready_n <= 1'b1;
      burst_ready_n <= 1'b1;
      bus_rdata <= 32'h0;
    end else begin
      fin = act && (!ready_n || (!burst_ready_n && !last_transfer_n));
      if (!addr_strobe_n) begin
        a = bus_addr;
        cnt = waits;
      end else if (act && !burst_ready_n) a = a + 32'h4;
      act = !addr_strobe_n || (act && !fin);
      hit = act && cnt == 8'h0;
      if (act && !hit) cnt = cnt - 8'h1; // Hold ready off for a wait
      ready_n <= !(hit && !use_burst); // Only with data, never idle
      burst_ready_n <= !(hit && use_burst); // One word each clock
      bus_rdata <= hit ? ~a : ~bus_rdata; // Stale data flips, never held
    end
  end
endmodule // memory_model

// ===== tb.sv
// Self-checking bench for the bus cycle controller
`timescale 1ns/1ps
module tb;
  import bus_cycle_pkg::*;
  typedef struct packed {
    logic wr; logic bu; logic ub; logic [7:0] w; logic [31:0] ad;
  } row_type; // Write, core burst, memory burst, waits, address
  logic clk, nrst, req_valid, req_ready, ub, rd_ready, rd_valid, wr_done;
  logic addr_strobe_n, bus_write, last_transfer_n, ready_n, burst_ready_n;
  logic [31:0] bus_addr, bus_wdata, bus_rdata;
  logic [7:0]  waits;
  req_type     req;
  word_type    rd_word;
  int          error_cnt, cmp_count;
  // Burst length a drained reader sees; a two-slot buffer cuts fills at two words
  localparam int FILL_WORDS = (BUF_DEPTH > 2) ? BURST_WORDS : 2;
  row_type rows [8] = '{'{0, 0, 0, 0, 32'h100}, '{1, 0, 0, 0, 32'h200},
    '{1, 0, 0, 2, 32'h300}, '{0, 0, 0, 3, 32'h400}, '{0, 1, 1, 0, 32'h1000},
    '{0, 1, 1, 2, 32'h2000}, '{0, 1, 0, 0, 32'h3000}, '{0, 0, 1, 1, 32'h4000}};
  always #2 clk = ~clk;
  bus_cycle_ctrl dut_u (.clk, .nrst, .req_valid, .req, .req_ready, .addr_strobe_n,
    .bus_addr, .bus_write, .bus_wdata, .last_transfer_n, .ready_n, .burst_ready_n,
    .bus_rdata, .wr_done, .rd_valid, .rd_word, .rd_ready);
  memory_model mem_u (.clk, .nrst, .addr_strobe_n, .bus_addr, .last_transfer_n,
    .waits, .use_burst(ub), .ready_n, .burst_ready_n, .bus_rdata);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One request, then its answer; st stalls the reader first
  task automatic run(input row_type r, input int st);
    int t;
    int k;
    t = 0;
    k = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{addr: r.ad, wdata: ~r.ad, write: r.wr, burst: r.bu};
    waits <= r.w;
    ub <= r.ub;
    rd_ready <= (st == 0);
    do @(negedge clk); while (req_ready !== 1'b1 && ++t < 50);
    @(posedge clk) req_valid <= 1'b0;
    if (st > 0) begin
      repeat (st) @(negedge clk);
      chk("held word", rd_valid, 1);
      chk("refused", req_ready, 0);
      @(posedge clk) rd_ready <= 1'b1;
    end
    for (t = 1; t < 60 && k >= 0; t++) begin
      @(negedge clk);
      if (r.wr && wr_done === 1'b1) begin
        chk("write clocks", t, T_MIN_CYCLES + 1 + r.w);
        chk("write addr", bus_addr, r.ad);
        chk("write data", bus_wdata, ~r.ad);
        k = -1;
      end else if (!r.wr && rd_valid === 1'b1) begin
        if (st == 0) chk("word clock", t, T_MIN_CYCLES + 1 + r.w + k);
        chk("read data", rd_word.data, ~(r.ad + 32'h4 * k));
        k++;
        if (rd_word.last === 1'b1) begin
          if (st == 0) chk("words", k, (r.bu && r.ub) ? FILL_WORDS : 1);
          k = -1;
        end
      end
    end
    if (k >= 0) begin
      error_cnt++;
      $display("[ERR] cycle end expected 1 seen 0");
      finish_test();
    end
  endtask
  initial begin
    {clk, nrst, req_valid, ub, waits, req, rd_ready} = '0;
    repeat (20) @(posedge clk);
    chk("reset outs", {req_ready, addr_strobe_n, last_transfer_n, wr_done, rd_valid}, 5'h1c);
    nrst <= 1'b1;
    rd_ready <= 1'b1;
    foreach (rows[i]) run(rows[i], 0);
    run('{0, 1, 1, 0, 32'h5000}, 12); // Reader stalls through a line fill
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{addr: 32'h600, wdata: 32'h1, write: 1'b1, burst: 1'b0};
    waits <= 8'h6;
    repeat (4) @(posedge clk);
    nrst <= 1'b0; // Reset in mid-wait
    req_valid <= 1'b0;
    @(negedge clk);
    chk("mid reset", {req_ready, addr_strobe_n, last_transfer_n, wr_done, rd_valid}, 5'h1c);
    @(posedge clk) nrst <= 1'b1;
    run(rows[4], 0);
    finish_test();
  end
endmodule // tb

// ===== word_buffer.sv
// Small ring buffer with valid and ready on both sides
`timescale 1ns/1ps

module word_buffer #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 2
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         in_valid,
  input  wire logic [WIDTH-1:0]             in_data,
  output logic                              in_ready,
  output logic                              out_valid,
  output logic [WIDTH-1:0]                  out_data,
  input  wire logic                         out_ready,
  output logic [$clog2(DEPTH+1)-1:0]        count_nxt
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;   // Pointer width
  localparam int CW = $clog2(DEPTH + 1);                 // Count width

  // Refuse shapes the pointer logic cannot serve
  if (DEPTH < 2) begin : g_depth_check
    $error("word_buffer needs DEPTH of at least 2");
  end

  // Whole buffer state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;     // Storage array
    logic [PW-1:0]               wr_ptr;  // Next slot to fill
    logic [PW-1:0]               rd_ptr;  // Oldest slot
    logic [CW-1:0]               count;   // Words held
    logic                        valid;   // Registered not empty
    logic [WIDTH-1:0]            head;    // Oldest word, kept in flops for the output
  } buf_state_type;

  buf_state_type s_r;    // Registered state
  buf_state_type s_nxt;  // Next state
  logic          push;   // Word enters
  logic          pop;    // Word leaves

  // Wrap a pointer at the depth, not at a power of two
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign in_ready  = (s_r.count != CW'(DEPTH));   // Honest full
  assign out_valid = s_r.valid;
  assign out_data  = s_r.head;
  assign count_nxt = s_nxt.count;

  // Next state: push and pop may share a cycle
  always_comb begin
    s_nxt = s_r;
    push  = in_valid && in_ready;
    pop   = s_r.valid && out_ready;
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = in_data;
      s_nxt.wr_ptr          = step(s_r.wr_ptr);
    end
    if (pop) begin
      s_nxt.rd_ptr = step(s_r.rd_ptr);
    end
    // Count moves only when one side acts alone
    if (push && !pop) begin
      s_nxt.count = s_r.count + CW'(1);
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - CW'(1);
    end
    s_nxt.valid = (s_nxt.count != '0);
    // Head copied ahead of time so the reader sees a flop, not a mux
    s_nxt.head  = s_nxt.mem[s_nxt.rd_ptr];
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // word_buffer
